// [tb_top.sv]
// Self-checking bench for the engage handshake block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	tseh_pkg::tseh_cfg_t cfg = '0;
	logic [3:0] crit_u = 4'h0;
	logic run = 1'b0;
	logic slip = 1'b0;
	logic [7:0] alive;
	logic [3:0] crit_c;
	logic eng, done, ded;
	int failures = 0;
	int compares = 0;
	int streak = 0;
	logic [7:0] prev = 8'h00;
	logic e_eng = 1'b0, e_done = 1'b0, hold = 1'b0, ok, nxt;
	localparam int ENG_AFTER = int'(tseh_pkg::ALT_NEED) +
		int'(tseh_pkg::CNT_LOAD);
	logic [3:0] e_crit = 4'h0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	tseh_user_model i_tseh_user_model (.clk_sys_i(clk_sys_i), .run_i(run),
		.slip_i(slip), .alive_o(alive));
	tseh_engage i_tseh_engage (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.cfg_i(cfg), .alive_bus_i(alive), .crit_user_i(crit_u),
		.crit_core_o(crit_c), .app_engaged_o(eng), .cfg_done_o(done),
		.cfg_pins_dedicated_o(ded));
	// Reference model; engage needs 4 hunt plus 16 countdown alternations
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			streak = 0;
			prev = 8'h00;
			{e_eng, e_done, hold, e_crit} <= '0;
		end else begin
			ok = (alive == tseh_pkg::PAT_A_DEF ||
				alive == tseh_pkg::PAT_B_DEF) && alive != prev &&
				(prev == tseh_pkg::PAT_A_DEF ||
				prev == tseh_pkg::PAT_B_DEF);
			streak = ok ? streak + 1 : 0;
			prev = alive;
			// Mask opens on the same edge as the flag rises
			nxt = e_eng | (streak >= ENG_AFTER);
			e_crit <= nxt ? crit_u : tseh_pkg::CRIT_IDLE;
			e_eng <= nxt;
			e_done <= cfg.stage1_start | cfg.stage2_done | hold;
			hold <= hold | cfg.stage2_done;
		end
	end
	task chk(input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task step(input int n, input logic slips);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_i);
			chk({3'h0, eng}, {3'h0, e_eng});
			chk(crit_c, e_crit);
			chk({3'h0, done}, {3'h0, e_done});
			chk({3'h0, ded}, 4'h1);
			crit_u = 4'($urandom);
			// Late update so the partner sees it one edge later
			slip <= slips && ($urandom % 8 == 0);
			cfg = '0;
		end
	endtask : step
	task end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	initial begin
		#50000;
		failures++;
		end_sim();
	end
	initial begin
		void'($urandom(3));
		step(10, 1'b0);
		reset_n_i = 1'b1;
		step(4, 1'b0);
		cfg.stage1_start = 1'b1;
		step(5, 1'b0);
		run <= 1'b1;
		step(80, 1'b1);
		step(30, 1'b0);
		cfg.stage2_done = 1'b1;
		step(4, 1'b0);
		cfg.stage1_start = 1'b1;
		step(3, 1'b0);
		reset_n_i = 1'b0;
		step(2, 1'b0);
		reset_n_i = 1'b1;
		step(30, 1'b0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire

// [tseh_engage.sv]
// Core-side engage handshake, configuration-complete pin and input masking
//Contract
//- Complete pin pulses once after stage one
//- Complete pin high and held after stage two
//- Accept eight-bit stage-two alive bus
//- Pattern pair parameterised, defaults 0x12, 0x9A
//- Detected pattern starts countdown before engaging
//- Engaged flag rises when countdown completes
//- Critical inputs held deasserted until engaged
//- Critical inputs pass through once engaged
//- Configuration pins stay dedicated after stage two
`timescale 1ns/10ps
`default_nettype none
module tseh_engage #(
	parameter logic [7:0] PAT_A = tseh_pkg::PAT_A_DEF,
	parameter logic [7:0] PAT_B = tseh_pkg::PAT_B_DEF
) (
	input wire logic clk_sys_i,           // User clock, 40 MHz
	input wire logic reset_n_i,           // Sync reset, active low
	input wire tseh_pkg::tseh_cfg_t cfg_i, // Config controller events
	input wire logic [7:0] alive_bus_i,   // Stage-two alive pattern
	input wire logic [3:0] crit_user_i,   // Critical inputs from user
	output logic [3:0] crit_core_o,       // Critical inputs to core
	output logic app_engaged_o,           // Engaged flag
	output logic cfg_done_o,              // Configuration-complete pin
	output logic cfg_pins_dedicated_o     // Config pins kept dedicated
);
	tseh_pkg::tseh_st_t st_reg;
	tseh_pkg::tseh_st_t st_next;
	logic is_pat;
	logic alt;

	// Bus comes from user logic on the same clock; no synchroniser
	assign is_pat = (alive_bus_i == PAT_A) || (alive_bus_i == PAT_B);
	assign alt = is_pat && st_reg.last_ok && (alive_bus_i != st_reg.last_pat);

	always_comb begin
		st_next = st_reg;
		st_next.last_pat = alive_bus_i;
		st_next.last_ok = is_pat;
		st_next.done_pin = st_reg.done_hold;
		if (cfg_i.stage1_start) begin
			st_next.done_pin = 1'b1;
		end
		if (cfg_i.stage2_done) begin
			st_next.done_hold = 1'b1;
			st_next.done_pin = 1'b1;
		end
		case (st_reg.state)
			tseh_pkg::TSEH_HUNT: begin
				if (alt) begin
					st_next.alt_cnt = st_reg.alt_cnt + tseh_pkg::ALT_ONE;
					if (st_next.alt_cnt == tseh_pkg::ALT_NEED) begin
						st_next.state = tseh_pkg::TSEH_COUNT;
						st_next.cnt = tseh_pkg::CNT_LOAD;
						st_next.alt_cnt = tseh_pkg::ALT_ZERO;
					end
				end else begin
					st_next.alt_cnt = tseh_pkg::ALT_ZERO;
				end
			end
			tseh_pkg::TSEH_COUNT: begin
				if (!alt) begin
					st_next.state = tseh_pkg::TSEH_HUNT;
				end else if (st_reg.cnt == tseh_pkg::CNT_ONE) begin
					st_next.state = tseh_pkg::TSEH_ENGAGED;
					st_next.engaged = 1'b1;
					st_next.cnt = tseh_pkg::CNT_ZERO;
				end else begin
					st_next.cnt = st_reg.cnt - tseh_pkg::CNT_ONE;
				end
			end
			tseh_pkg::TSEH_ENGAGED: begin
				// Engaged is sticky until reset; later pattern loss ignored
				st_next.engaged = 1'b1;
			end
			default: begin
				st_next.state = tseh_pkg::TSEH_HUNT;
			end
		endcase
		// Mask glitches from a half-loaded second stage
		if (st_next.engaged) begin
			st_next.crit = crit_user_i;
		end else begin
			st_next.crit = tseh_pkg::CRIT_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			st_reg <= '{state: tseh_pkg::TSEH_HUNT, last_pat: 8'h00,
				last_ok: 1'b0, alt_cnt: tseh_pkg::ALT_ZERO,
				cnt: tseh_pkg::CNT_ZERO, engaged: 1'b0, done_pin: 1'b0,
				done_hold: 1'b0, crit: tseh_pkg::CRIT_IDLE};
		end else begin
			st_reg <= st_next;
		end
	end

	assign crit_core_o = st_reg.crit;
	assign app_engaged_o = st_reg.engaged;
	assign cfg_done_o = st_reg.done_pin;
	// Persist is never released in this flow
	assign cfg_pins_dedicated_o = 1'b1;

	property p_hold_masked;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		!app_engaged_o |-> (crit_core_o == tseh_pkg::CRIT_IDLE);
	endproperty
	a_hold_masked: assert property (p_hold_masked)
		else $error("critical inputs leaked before engage");

	property p_pass;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		app_engaged_o && $past(app_engaged_o) |->
			crit_core_o == $past(crit_user_i);
	endproperty
	a_pass: assert property (p_pass)
		else $error("critical inputs not passed after engage");

	property p_count_first;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(app_engaged_o) |-> $past(st_reg.state) == tseh_pkg::TSEH_COUNT;
	endproperty
	a_count_first: assert property (p_count_first)
		else $error("engaged without countdown");

	property p_sticky;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		app_engaged_o |=> app_engaged_o;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("engaged flag dropped");

	property p_break;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		(st_reg.state == tseh_pkg::TSEH_COUNT) && !alt |=>
			st_reg.state == tseh_pkg::TSEH_HUNT;
	endproperty
	a_break: assert property (p_break)
		else $error("countdown not restarted on broken pattern");

	property p_done1;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		cfg_i.stage1_start |=> cfg_done_o;
	endproperty
	a_done1: assert property (p_done1)
		else $error("complete pin missed stage one pulse");

	sequence s_stage2;
		cfg_i.stage2_done ##1 1'b1;
	endsequence
	property p_done2;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_stage2 |-> cfg_done_o [*8];
	endproperty
	a_done2: assert property (p_done2)
		else $error("complete pin not held after stage two");

	property p_dedic;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		cfg_pins_dedicated_o;
	endproperty
	a_dedic: assert property (p_dedic)
		else $error("configuration pins released");

	// Hunt must see the full run of alternations before counting
	property p_hunt_hold;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		(st_reg.state == tseh_pkg::TSEH_HUNT) && !(alt &&
			(st_reg.alt_cnt == tseh_pkg::ALT_NEED - tseh_pkg::ALT_ONE))
			|=> st_reg.state == tseh_pkg::TSEH_HUNT;
	endproperty
	a_hunt_hold: assert property (p_hunt_hold)
		else $error("countdown entered before full alternation run");

	// Last hunt alternation, the step into the countdown
	sequence s_hunt_last;
		(st_reg.state == tseh_pkg::TSEH_HUNT) && alt &&
			(st_reg.alt_cnt == tseh_pkg::ALT_NEED - tseh_pkg::ALT_ONE);
	endsequence
	property p_count_load;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_hunt_last |=> (st_reg.state == tseh_pkg::TSEH_COUNT) &&
			(st_reg.cnt == tseh_pkg::CNT_LOAD);
	endproperty
	a_count_load: assert property (p_count_load)
		else $error("countdown not loaded after hunt");

	sequence s_count_step;
		(st_reg.state == tseh_pkg::TSEH_COUNT) && alt &&
			(st_reg.cnt != tseh_pkg::CNT_ONE);
	endsequence
	property p_count_step;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_count_step |=> (st_reg.state == tseh_pkg::TSEH_COUNT) &&
			!app_engaged_o &&
			(st_reg.cnt == $past(st_reg.cnt) - tseh_pkg::CNT_ONE);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("countdown did not step down");

	sequence s_count_end;
		(st_reg.state == tseh_pkg::TSEH_COUNT) && alt &&
			(st_reg.cnt == tseh_pkg::CNT_ONE);
	endsequence
	property p_engage_end;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_count_end |=> app_engaged_o &&
			(st_reg.state == tseh_pkg::TSEH_ENGAGED);
	endproperty
	a_engage_end: assert property (p_engage_end)
		else $error("engaged flag missing after countdown");

	property p_hunt_clear;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		(st_reg.state == tseh_pkg::TSEH_HUNT) && !alt |=>
			st_reg.alt_cnt == tseh_pkg::ALT_ZERO;
	endproperty
	a_hunt_clear: assert property (p_hunt_clear)
		else $error("hunt count kept over a broken pattern");

	// A lone stage-one event must give a single-cycle pulse
	sequence s_lone_pulse;
		cfg_i.stage1_start && !st_reg.done_hold && !cfg_i.stage2_done
			##1 !cfg_i.stage1_start && !cfg_i.stage2_done;
	endsequence
	property p_done_pulse;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		s_lone_pulse |=> !cfg_done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("complete pin pulse too long");

	property p_done_hold;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		st_reg.done_hold |-> cfg_done_o;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("complete pin dropped after stage two");

	// No disable here: this one watches the reset itself
	property p_reset_clear;
		@(posedge clk_sys_i)
		!reset_n_i |=> !app_engaged_o && !cfg_done_o &&
			(crit_core_o == tseh_pkg::CRIT_IDLE);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("outputs not cleared by reset");
endmodule : tseh_engage
`default_nettype wire

// [tseh_pkg.sv]
// Package for the two-stage engage handshake block
package tseh_pkg;
	localparam int PAT_W = 8;
	localparam logic [7:0] PAT_A_DEF = 8'h12;
	localparam logic [7:0] PAT_B_DEF = 8'h9A;
	// Countdown length in user clock cycles
	localparam logic [7:0] CNT_LOAD = 8'h10;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	// Consecutive alternations needed before the countdown starts
	localparam logic [2:0] ALT_NEED = 3'h4;
	localparam logic [2:0] ALT_ZERO = 3'h0;
	localparam logic [2:0] ALT_ONE = 3'h1;
	localparam int CRIT_W = 4;
	localparam logic [3:0] CRIT_IDLE = 4'h0;

	typedef enum logic [1:0] {
		TSEH_HUNT = 2'b00,
		TSEH_COUNT = 2'b01,
		TSEH_ENGAGED = 2'b10
	} tseh_state_t;

	typedef struct packed {
		logic stage1_start; // Pulse: first stage startup ran
		logic stage2_done;  // Pulse: second stage finished loading
	} tseh_cfg_t;

	typedef struct packed {
		tseh_state_t state;
		logic [7:0] last_pat;
		logic last_ok;
		logic [2:0] alt_cnt;
		logic [7:0] cnt;
		logic engaged;
		logic done_pin;
		logic done_hold;
		logic [3:0] crit;
	} tseh_st_t;
endpackage : tseh_pkg

// [tseh_user_model.sv]
// Second-stage user logic model driving the alive pattern
`timescale 1ns/10ps
`default_nettype none
module tseh_user_model (
	input wire logic clk_sys_i, // User clock
	input wire logic run_i,     // Stage two started
	input wire logic slip_i,    // Hold last value one cycle
	output logic [7:0] alive_o  // Alive pattern to core
);
	logic ph = 1'b0;
	initial alive_o = 8'h00;
	// Counting bus before startup so stale values never look valid
	always @(negedge clk_sys_i) begin
		if (!run_i) begin
			alive_o <= alive_o + 8'h01;
		end else if (!slip_i) begin
			ph <= ~ph;
			alive_o <= ph ? tseh_pkg::PAT_B_DEF : tseh_pkg::PAT_A_DEF;
		end
	end
endmodule : tseh_user_model
`default_nettype wire
